// ==== src/tmr3_timer.sv ====
`timescale 1ns/1ps
`include "tmr3_defs.svh"
module tmr3_timer
   import tmr3_pkg::*;
(
   input wire logic I_CORE_CLK,
   input wire logic I_ARST_N,
   input wire logic I_WB_CYC,
   input wire logic I_WB_STB,
   input wire logic I_WB_WE,
   input wire logic [3:0] I_WB_ADR,
   input wire logic [3:0] I_WB_SEL,
   input wire logic [31:0] I_WB_DAT,
   output logic [31:0] O_WB_DAT,
   output logic O_WB_ACK,
   input wire logic I_TRIG_PIN,
   input wire logic I_COUNT_PIN,
   input wire logic I_T1_OVF,
   output logic O_SER_TX_CLK,
   output logic O_SER_RX_CLK,
   output logic O_IRQ
);
   tmr3_evt_if trig_if ();
   tmr3_evt_if cnt_if ();
   tmr3_fall_det u_trig (
      .i_clk(I_CORE_CLK),
      .i_rst_n(I_ARST_N),
      .i_pin(I_TRIG_PIN),
      .evt(trig_if.src)
   );
   tmr3_fall_det u_cnt (
      .i_clk(I_CORE_CLK),
      .i_rst_n(I_ARST_N),
      .i_pin(I_COUNT_PIN),
      .evt(cnt_if.src)
   );

   logic [7:0] ctrl_q;
   logic [15:0] cnt_q;
   logic [15:0] cap_q;
   logic [7:0] pre_q;
   logic [31:0] rdat_d;
   logic acc;
   logic wr_ctrl;
   logic wr_lo;
   logic wr_hi;
   logic wr_cap;
   logic baud;
   logic tick;
   logic ovf;
   logic trig;
   logic ovf_set;
   logic ext_set;
   tmr3_mode_t mode;

   assign acc = I_WB_CYC & I_WB_STB & ~O_WB_ACK;
   assign wr_ctrl = acc & I_WB_WE & I_WB_SEL[0] &
      (I_WB_ADR == `TMR3_ADR_CTRL);
   assign wr_lo = acc & I_WB_WE & I_WB_SEL[0] &
      (I_WB_ADR == `TMR3_ADR_CNT_LO);
   assign wr_hi = acc & I_WB_WE & I_WB_SEL[0] &
      (I_WB_ADR == `TMR3_ADR_CNT_HI);
   assign wr_cap = acc & I_WB_WE & (I_WB_ADR == `TMR3_ADR_CAP_LO);

   assign baud = ctrl_q[`TMR3_BIT_TXSEL] | ctrl_q[`TMR3_BIT_RXSEL];

   always_comb begin
      if (!ctrl_q[`TMR3_BIT_RUN]) begin
         mode = TMR3_OFF;
      end else if (baud) begin
         mode = TMR3_BAUD;
      end else if (ctrl_q[`TMR3_BIT_CAPSEL]) begin
         mode = TMR3_CAPTURE;
      end else begin
         mode = TMR3_RELOAD;
      end
   end

   // Baud mode always counts state times; else the select bit chooses.
   always_comb begin
      if (mode == TMR3_OFF) begin
         tick = 1'b0;
      end else if (baud || !ctrl_q[`TMR3_BIT_CTSEL]) begin
         tick = (pre_q == 8'(`TMR3_STATE_CYC - 1));
      end else begin
         tick = cnt_if.fall;
      end
   end

   assign ovf = tick & (cnt_q == 16'hffff);
   assign trig = trig_if.fall & ctrl_q[`TMR3_BIT_EXTEN];
   assign ovf_set = ovf & (mode != TMR3_BAUD);
   assign ext_set = trig & (mode != TMR3_OFF);

   always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         pre_q <= 8'h00;
      end else if (mode == TMR3_OFF ||
                   pre_q == 8'(`TMR3_STATE_CYC - 1)) begin
         pre_q <= 8'h00;
      end else begin
         pre_q <= pre_q + 8'h01;
      end
   end

   // A hardware set in the cycle of a software clear keeps the flag.
   always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         ctrl_q <= `TMR3_CTRL_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= I_WB_DAT[7:0];
         end
         if (ovf_set) begin
            ctrl_q[`TMR3_BIT_OVFFLG] <= 1'b1;
         end
         if (ext_set) begin
            ctrl_q[`TMR3_BIT_EXTFLG] <= 1'b1;
         end
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         cnt_q <= 16'h0000;
      end else if (mode == TMR3_CAPTURE && trig) begin
         cnt_q <= 16'h0000;
      end else if (mode == TMR3_RELOAD && trig) begin
         cnt_q <= cap_q;
      end else if (ovf && mode != TMR3_CAPTURE) begin
         cnt_q <= cap_q;
      end else if (tick) begin
         cnt_q <= cnt_q + 16'h0001;
      end else if (wr_lo) begin
         cnt_q[7:0] <= I_WB_DAT[7:0];
      end else if (wr_hi) begin
         cnt_q[15:8] <= I_WB_DAT[7:0];
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         cap_q <= 16'h0000;
      end else if (mode == TMR3_CAPTURE && trig) begin
         cap_q <= cnt_q;
      end else if (wr_cap) begin
         if (I_WB_SEL[0]) begin
            cap_q[7:0] <= I_WB_DAT[7:0];
         end
         if (I_WB_SEL[1]) begin
            cap_q[15:8] <= I_WB_DAT[15:8];
         end
      end
   end

   // Overflow pulses are delayed by one register stage to the serial port.
   always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         O_SER_TX_CLK <= 1'b0;
         O_SER_RX_CLK <= 1'b0;
      end else begin
         O_SER_TX_CLK <= ctrl_q[`TMR3_BIT_TXSEL] ? ovf : I_T1_OVF;
         O_SER_RX_CLK <= ctrl_q[`TMR3_BIT_RXSEL] ? ovf : I_T1_OVF;
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         O_IRQ <= 1'b0;
      end else begin
         O_IRQ <= ctrl_q[`TMR3_BIT_OVFFLG] | ctrl_q[`TMR3_BIT_EXTFLG];
      end
   end

   always_comb begin
      rdat_d = 32'h0000_0000;
      case (I_WB_ADR)
         `TMR3_ADR_CTRL: rdat_d[7:0] = ctrl_q;
         `TMR3_ADR_CNT_LO: rdat_d[7:0] = cnt_q[7:0];
         `TMR3_ADR_CNT_HI: rdat_d[7:0] = cnt_q[15:8];
         `TMR3_ADR_CAP_LO: rdat_d[15:0] = cap_q;
         default: rdat_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         O_WB_ACK <= 1'b0;
         O_WB_DAT <= 32'h0000_0000;
      end else begin
         O_WB_ACK <= acc;
         O_WB_DAT <= rdat_d;
      end
   end

   ovf_flag_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      ovf_set |=> ctrl_q[`TMR3_BIT_OVFFLG])
      else $error("overflow flag not set");
   baud_noflag_a: assert property (@(posedge I_CORE_CLK)
      disable iff (!I_ARST_N)
      (mode == TMR3_BAUD && !wr_ctrl) |=>
      $stable(ctrl_q[`TMR3_BIT_OVFFLG]) || !$past(ctrl_q[`TMR3_BIT_RUN]))
      else $error("overflow flag moved in baud mode");
   tx_route_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      (ctrl_q[`TMR3_BIT_TXSEL] && ovf) |=> O_SER_TX_CLK)
      else $error("transmit clock missed overflow");
   rx_route_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      (!ctrl_q[`TMR3_BIT_RXSEL]) |=> O_SER_RX_CLK == $past(I_T1_OVF))
      else $error("receive clock not from timer one");
   run_off_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      (!ctrl_q[`TMR3_BIT_RUN] && !wr_lo && !wr_hi) |=> $stable(cnt_q))
      else $error("counter moved while stopped");
   cap_copy_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      (mode == TMR3_CAPTURE && trig) |=>
      cap_q == $past(cnt_q) && cnt_q == 16'h0000)
      else $error("capture failed");
   reload_val_a: assert property (@(posedge I_CORE_CLK)
      disable iff (!I_ARST_N)
      (ovf && mode == TMR3_BAUD) |=> cnt_q == $past(cap_q))
      else $error("reload value wrong");
   baud_trig_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      (mode == TMR3_BAUD && trig && !ovf && !tick) |=>
      $stable(cnt_q) && ctrl_q[`TMR3_BIT_EXTFLG])
      else $error("baud trigger reloaded");
   trig_off_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      (!ctrl_q[`TMR3_BIT_EXTEN] && !wr_ctrl && !ctrl_q[`TMR3_BIT_EXTFLG])
      |=> !ctrl_q[`TMR3_BIT_EXTFLG])
      else $error("trigger not ignored");

   // The bus answers in exactly one cycle and never holds the acknowledge.
   ack_answer_a: assert property (@(posedge I_CORE_CLK)
      disable iff (!I_ARST_N)
      acc |=> O_WB_ACK)
      else $error("acknowledge missing");

   ack_pulse_a: assert property (@(posedge I_CORE_CLK)
      disable iff (!I_ARST_N)
      O_WB_ACK |=> !O_WB_ACK)
      else $error("acknowledge held too long");

   tx_t1_a: assert property (@(posedge I_CORE_CLK)
      disable iff (!I_ARST_N)
      (!ctrl_q[`TMR3_BIT_TXSEL]) |=> O_SER_TX_CLK == $past(I_T1_OVF))
      else $error("transmit clock not from timer one");

   rx_ovf_a: assert property (@(posedge I_CORE_CLK)
      disable iff (!I_ARST_N)
      (ctrl_q[`TMR3_BIT_RXSEL] && ovf) |=> O_SER_RX_CLK)
      else $error("receive clock missed overflow");

   baud_noset_a: assert property (@(posedge I_CORE_CLK)
      disable iff (!I_ARST_N)
      (mode == TMR3_BAUD) |-> !ovf_set)
      else $error("overflow flag armed in baud mode");

   baud_tick_a: assert property (@(posedge I_CORE_CLK)
      disable iff (!I_ARST_N)
      (mode == TMR3_BAUD) |-> tick == (pre_q == 8'(`TMR3_STATE_CYC - 1)))
      else $error("baud mode not on state time");

   pre_range_a: assert property (@(posedge I_CORE_CLK)
      disable iff (!I_ARST_N)
      pre_q <= 8'(`TMR3_STATE_CYC - 1))
      else $error("prescaler out of range");

   off_notick_a: assert property (@(posedge I_CORE_CLK)
      disable iff (!I_ARST_N)
      (mode == TMR3_OFF) |-> !tick && !ovf)
      else $error("timer ticks while off");

   baud_decode_a: assert property (@(posedge I_CORE_CLK)
      disable iff (!I_ARST_N)
      (baud && ctrl_q[`TMR3_BIT_RUN]) |-> mode == TMR3_BAUD)
      else $error("baud mode not decoded");

   cap_decode_a: assert property (@(posedge I_CORE_CLK)
      disable iff (!I_ARST_N)
      (ctrl_q[`TMR3_BIT_RUN] && !baud && ctrl_q[`TMR3_BIT_CAPSEL])
      |-> mode == TMR3_CAPTURE)
      else $error("capture mode not decoded");

   trig_gate_a: assert property (@(posedge I_CORE_CLK)
      disable iff (!I_ARST_N)
      (!ctrl_q[`TMR3_BIT_EXTEN]) |-> !trig)
      else $error("trigger passed while disabled");

   ext_flag_a: assert property (@(posedge I_CORE_CLK)
      disable iff (!I_ARST_N)
      ext_set |=> ctrl_q[`TMR3_BIT_EXTFLG])
      else $error("external flag not set");

   reload_trig_a: assert property (@(posedge I_CORE_CLK)
      disable iff (!I_ARST_N)
      (mode == TMR3_RELOAD && trig) |=> cnt_q == $past(cap_q))
      else $error("trigger reload wrong");

   reload_ovf_a: assert property (@(posedge I_CORE_CLK)
      disable iff (!I_ARST_N)
      (mode == TMR3_RELOAD && ovf && !trig) |=> cnt_q == $past(cap_q))
      else $error("overflow reload wrong");

   // Events only count outside baud mode, where the state time rules.
   event_cnt_a: assert property (@(posedge I_CORE_CLK)
      disable iff (!I_ARST_N)
      (mode != TMR3_OFF && mode != TMR3_BAUD &&
      ctrl_q[`TMR3_BIT_CTSEL] && cnt_if.fall && !trig && !ovf)
      |=> cnt_q == $past(cnt_q) + 16'h0001)
      else $error("event not counted");

   time_only_a: assert property (@(posedge I_CORE_CLK)
      disable iff (!I_ARST_N)
      (mode != TMR3_OFF && !ctrl_q[`TMR3_BIT_CTSEL] &&
      pre_q != 8'(`TMR3_STATE_CYC - 1)) |-> !tick)
      else $error("timer ticked off state time");

   ovf_hold_a: assert property (@(posedge I_CORE_CLK)
      disable iff (!I_ARST_N)
      (ctrl_q[`TMR3_BIT_OVFFLG] && !wr_ctrl) |=> ctrl_q[`TMR3_BIT_OVFFLG])
      else $error("overflow flag cleared by hardware");

   ext_hold_a: assert property (@(posedge I_CORE_CLK)
      disable iff (!I_ARST_N)
      (ctrl_q[`TMR3_BIT_EXTFLG] && !wr_ctrl) |=> ctrl_q[`TMR3_BIT_EXTFLG])
      else $error("external flag cleared by hardware");

   cap_hold_a: assert property (@(posedge I_CORE_CLK)
      disable iff (!I_ARST_N)
      (!(mode == TMR3_CAPTURE && trig) && !wr_cap) |=> $stable(cap_q))
      else $error("capture pair changed unasked");

   irq_level_a: assert property (@(posedge I_CORE_CLK)
      disable iff (!I_ARST_N)
      ctrl_q[`TMR3_BIT_OVFFLG] |=> O_IRQ)
      else $error("interrupt missing for overflow");

   irq_ext_a: assert property (@(posedge I_CORE_CLK)
      disable iff (!I_ARST_N)
      ctrl_q[`TMR3_BIT_EXTFLG] |=> O_IRQ)
      else $error("interrupt missing for trigger");

   cap_wrap_a: assert property (@(posedge I_CORE_CLK)
      disable iff (!I_ARST_N)
      (mode == TMR3_CAPTURE && ovf && !trig) |=> cnt_q == 16'h0000)
      else $error("capture mode overflow did not wrap");
endmodule : tmr3_timer

// ==== src/tmr3_defs.svh ====
`ifndef TMR3_DEFS_SVH
`define TMR3_DEFS_SVH
`define TMR3_ADR_CTRL 4'h0
`define TMR3_ADR_CNT_LO 4'h4
`define TMR3_ADR_CNT_HI 4'h8
`define TMR3_ADR_CAP_LO 4'hc
`define TMR3_BIT_CAPSEL 0
`define TMR3_BIT_CTSEL 1
`define TMR3_BIT_RUN 2
`define TMR3_BIT_EXTEN 3
`define TMR3_BIT_TXSEL 4
`define TMR3_BIT_RXSEL 5
`define TMR3_BIT_EXTFLG 6
`define TMR3_BIT_OVFFLG 7
`define TMR3_CTRL_RST 8'h00
`define TMR3_CLK_MHZ 200
`define TMR3_STATE_NS 10
`define TMR3_STATE_CYC ((`TMR3_STATE_NS * `TMR3_CLK_MHZ) / 1000)
`endif

// ==== src/tmr3_pkg.sv ====
package tmr3_pkg;
   typedef enum logic [1:0] {
      TMR3_OFF,
      TMR3_RELOAD,
      TMR3_CAPTURE,
      TMR3_BAUD
   } tmr3_mode_t;
endpackage : tmr3_pkg

// ==== src/tmr3_evt_if.sv ====
`timescale 1ns/1ps
interface tmr3_evt_if;
   logic fall;
   modport src (output fall);
   modport dst (input fall);
endinterface : tmr3_evt_if

// ==== src/tmr3_fall_det.sv ====
`timescale 1ns/1ps
module tmr3_fall_det (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_pin,
   tmr3_evt_if.src evt
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   // Two stages settle the pin; the second and third stages feed the edge compare.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
         s3_q <= 1'b1;
      end else begin
         s1_q <= i_pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   assign evt.fall = s3_q & ~s2_q;
endmodule : tmr3_fall_det

// ==== bench/tmr3_serial_model.sv ====
`timescale 1ns/1ps
module tmr3_serial_model (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_tx_clk,
   input wire logic i_rx_clk,
   output logic o_t1_ovf,
   output logic o_trig_pin
);
   int tx_n = 0;
   int rx_n = 0;
   logic [2:0] div_q = 3'h0;
   initial o_t1_ovf = 1'b0;
   // The trigger line has a pull-up, so it idles high between events.
   initial o_trig_pin = 1'b1;
   always @(posedge i_clk) begin
      div_q <= i_rst_n ? div_q + 3'h1 : 3'h0;
      o_t1_ovf <= (div_q == 3'h7);
      if (i_tx_clk === 1'b1) tx_n <= tx_n + 1;
      if (i_rx_clk === 1'b1) rx_n <= rx_n + 1;
   end
   // Low for eight cycles so the synchroniser sees it whatever the phase.
   task automatic trig_fall();
      @(posedge i_clk);
      o_trig_pin <= 1'b0;
      repeat (8) @(posedge i_clk);
      o_trig_pin <= 1'b1;
      repeat (6) @(posedge i_clk);
   endtask : trig_fall
endmodule : tmr3_serial_model

// ==== bench/timer2_capture_reload_baud_bench.sv ====
`timescale 1ns/1ps
module timer2_capture_reload_baud_bench;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic ack, t1, trig, txc, rxc, irq;
   logic cnt_pin = 1'b1;
   logic [7:0] bm [3] = '{8'h14, 8'h24, 8'h34};
   int err_total = 0;
   int samples_checked = 0;
   int tx0, rx0;
   always #2.5 clk = ~clk;
   tmr3_timer uut (.I_CORE_CLK(clk), .I_ARST_N(arst_n), .I_WB_CYC(cyc),
      .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel),
      .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
      .I_TRIG_PIN(trig), .I_COUNT_PIN(cnt_pin), .I_T1_OVF(t1),
      .O_SER_TX_CLK(txc), .O_SER_RX_CLK(rxc), .O_IRQ(irq));
   tmr3_serial_model ser (.i_clk(clk), .i_rst_n(arst_n), .i_tx_clk(txc),
      .i_rx_clk(rxc), .o_t1_ovf(t1), .o_trig_pin(trig));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
      input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      wdat <= d;
      @(posedge clk);
      while (ack !== 1'b1 && n < 20) begin
         n++;
         @(posedge clk);
      end
      if (n == 20) begin
         err_total++;
         final_report();
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb
   task automatic wr(input logic [3:0] a, input logic [3:0] s,
      input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, s, d, q);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      logic [31:0] q;
      wb(1'b0, a, 4'hf, 32'h0, q);
      chk(q, exp);
   endtask : rd
   task automatic cnt_fall();
      cnt_pin <= 1'b0;
      repeat (6) @(posedge clk);
      cnt_pin <= 1'b1;
      repeat (6) @(posedge clk);
   endtask : cnt_fall
   // Timer overflow every 32 cycles gives 10 pulses; timer 1 gives 40.
   function automatic logic [31:0] in_rng(input int n, input logic t);
      return t ? 32'(n >= 9 && n <= 11) : 32'(n >= 39 && n <= 41);
   endfunction : in_rng
   task automatic final_report();
      $display("Mismatches %0d, comparisons %0d", err_total, samples_checked);
      if (err_total == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : final_report
   initial begin
      repeat (10000) @(posedge clk);
      err_total++;
      final_report();
   end
   initial begin
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      rd(4'h0, 32'h0);
      rd(4'h1, 32'h0);
      foreach (bm[i]) begin
         wr(4'h0, 4'h1, {24'h0, bm[i] & 8'hfb});
         wr(4'hc, 4'h3, 32'hfff0);
         wr(4'h4, 4'h1, 32'hf0);
         wr(4'h8, 4'h1, 32'hff);
         tx0 = ser.tx_n;
         rx0 = ser.rx_n;
         wr(4'h0, 4'h1, {24'h0, bm[i]});
         repeat (320) @(posedge clk);
         chk(in_rng(ser.tx_n - tx0, bm[i][4]), 32'h1);
         chk(in_rng(ser.rx_n - rx0, bm[i][5]), 32'h1);
         wr(4'h0, 4'h1, {24'h0, bm[i] & 8'hfb});
         rd(4'h0, {24'h0, bm[i] & 8'hfb});
      end
      wr(4'h0, 4'h1, 32'h1c);
      ser.trig_fall();
      rd(4'h0, 32'h5c);
      wr(4'h0, 4'h1, 32'h0);
      wr(4'hc, 4'h3, 32'hfffe);
      wr(4'h4, 4'h1, 32'hfe);
      wr(4'h8, 4'h1, 32'hff);
      wr(4'h0, 4'h1, 32'h04);
      repeat (40) @(posedge clk);
      rd(4'h0, 32'h84);
      chk({31'h0, irq}, 32'h1);
      // Stop first so a late overflow cannot win against the clear.
      wr(4'h0, 4'h1, 32'h80);
      wr(4'h0, 4'h1, 32'h0);
      rd(4'h0, 32'h0);
      wr(4'h8, 4'h1, 32'h12);
      wr(4'h4, 4'h1, 32'h34);
      wr(4'h0, 4'h1, 32'h02);
      cnt_fall();
      rd(4'h4, 32'h34);
      wr(4'h0, 4'h1, 32'h07);
      ser.trig_fall();
      rd(4'h0, 32'h07);
      wr(4'h0, 4'h1, 32'h0f);
      repeat (3) cnt_fall();
      ser.trig_fall();
      rd(4'hc, 32'h1237);
      rd(4'h4, 32'h0);
      rd(4'h0, 32'h4f);
      wr(4'h0, 4'h1, 32'h0e);
      ser.trig_fall();
      rd(4'h4, 32'h37);
      rd(4'h8, 32'h12);
      rd(4'h0, 32'h4e);
      final_report();
   end
endmodule : timer2_capture_reload_baud_bench
